// *** logic/tcsr_top.sv ***
`include "tcsr_regs.svh"
module tcsr_top #(
   parameter logic [35:0] AUTO_FSK_CAL_ENABLE_CYCLES = 36'(`TCSR_AUTO_FSK_CAL_ENABLE_CYCLES)
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clkEn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // device pins
   input wire logic enablePin,
   input wire logic txRxPin,
   // analog status
   input wire logic pllLockRaw,
   input wire logic lnaHighRaw,
   input wire logic xtalAliveRaw,
   input wire logic pollCalBusy,
   input wire logic fskCalBusy,
   // drx sequencer status
   input wire logic drxOnPeriod,
   // controls to the radio
   output logic agcLockEnable,
   output logic manualLevelMode,
   output logic lnaForceHigh,
   output logic peakTrackForce,
   output logic pollCalStart,
   output logic fskCalStart,
   output logic deepSleep,
   output logic fskMode,
   output logic txMode,
   output logic rxMode,
   output logic discontinuousRxEnable,
   output tcsr_pkg::tcsr_sel_t offPrescale,
   output tcsr_pkg::tcsr_sel_t onPrescale,
   output logic [23:0] agcDwellCycles,
   output logic dataEnable,
   output logic dividedClockPin
);
   import tcsr_pkg::*;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [7:0] syncA_q;
   logic [7:0] syncB_q;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         syncA_q <= 8'h00;
         syncB_q <= 8'h00;
      end else if (clkEn) begin
         syncA_q <= {
            drxOnPeriod,
            fskCalBusy,
            pollCalBusy,
            xtalAliveRaw,
            lnaHighRaw,
            pllLockRaw,
            txRxPin,
            enablePin
         };
         syncB_q <= syncA_q;
      end
   end
   logic enS, txRxS, lockS, lnaS, xtalS, pBusyS, fBusyS, onS;
   assign {onS, fBusyS, pBusyS, xtalS, lnaS, lockS, txRxS, enS} = syncB_q;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   function automatic logic hitIdx(input logic [11:0] a, input logic [7:0] idx);
      hitIdx = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
   endfunction : hitIdx

   logic access, wrEn, mapped;
   assign access = psel && penable && !pready;
   assign mapped = hitIdx(paddr, `TCSR_IDX_CONTROL) || hitIdx(paddr, `TCSR_IDX_CONFIG0)
                || hitIdx(paddr, `TCSR_IDX_CONFIG1) || hitIdx(paddr, `TCSR_IDX_STATUS);
   assign wrEn = access && pwrite && pstrb[0] && mapped;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   tcsr_byte_t control_q, config0_q, config1_q;
   logic pollDone, fskDone;
   tcsr_cal_t pollSt_q, fskSt_q;
   logic acalFire;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         config0_q <= `TCSR_RST_CONFIG0;
      end else if (clkEn && wrEn && hitIdx(paddr, `TCSR_IDX_CONFIG0)) begin
         config0_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         config1_q <= `TCSR_RST_CONFIG1;
      end else if (clkEn && wrEn && hitIdx(paddr, `TCSR_IDX_CONFIG1)) begin
         config1_q <= pwdata[7:0] & `TCSR_CF1_MASK;
      end
   end

   // trigger bits self clear on completion; a fresh write wins over the clear
   tcsr_byte_t ctlNext;
   always_comb begin
      ctlNext = control_q;
      if (pollDone) begin
         ctlNext[`TCSR_CTL_POLL_TIMER_CAL_START] = 1'b0;
      end
      if (fskDone) begin
         ctlNext[`TCSR_CTL_FSK_CAL_START] = 1'b0;
      end
      if (acalFire) begin
         ctlNext[`TCSR_CTL_FSK_CAL_START] = 1'b1;
      end
      if (wrEn && hitIdx(paddr, `TCSR_IDX_CONTROL)) begin
         ctlNext = pwdata[7:0] & `TCSR_CTL_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         control_q <= `TCSR_RST_CONTROL;
      end else if (clkEn) begin
         control_q <= ctlNext;
      end
   end

   // ----------------------------------------
   // calibration sequencing
   // ----------------------------------------
   // run starts with the trigger bit, ends when busy seen high then low
   logic pollSeen_q, fskSeen_q, pollDoneSt_q, fskDoneSt_q;

   // done strobes clear the trigger bit in the same edge the state returns idle
   assign pollDone = (pollSt_q == TCSR_CAL_RUN) && pollSeen_q && !pBusyS;
   assign fskDone = (fskSt_q == TCSR_CAL_RUN) && fskSeen_q && !fBusyS;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pollSt_q <= TCSR_CAL_IDLE;
         pollSeen_q <= 1'b0;
         pollDoneSt_q <= 1'b0;
      end else if (clkEn) begin
         case (pollSt_q)
            TCSR_CAL_IDLE: begin
               if (control_q[`TCSR_CTL_POLL_TIMER_CAL_START]) begin
                  pollSt_q <= TCSR_CAL_RUN;
                  pollSeen_q <= 1'b0;
                  pollDoneSt_q <= 1'b0;
               end
            end
            TCSR_CAL_RUN: begin
               if (pBusyS) begin
                  pollSeen_q <= 1'b1;
               end
               if (pollDone) begin
                  pollSt_q <= TCSR_CAL_IDLE;
                  pollDoneSt_q <= 1'b1;
               end
            end
            default: pollSt_q <= TCSR_CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fskSt_q <= TCSR_CAL_IDLE;
         fskSeen_q <= 1'b0;
         fskDoneSt_q <= 1'b0;
      end else if (clkEn) begin
         case (fskSt_q)
            TCSR_CAL_IDLE: begin
               if (control_q[`TCSR_CTL_FSK_CAL_START]) begin
                  fskSt_q <= TCSR_CAL_RUN;
                  fskSeen_q <= 1'b0;
                  fskDoneSt_q <= 1'b0;
               end
            end
            TCSR_CAL_RUN: begin
               if (fBusyS) begin
                  fskSeen_q <= 1'b1;
               end
               if (fskDone) begin
                  fskSt_q <= TCSR_CAL_IDLE;
                  fskDoneSt_q <= 1'b1;
               end
            end
            default: fskSt_q <= TCSR_CAL_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // auto fsk calibration timer
   // ----------------------------------------
   logic [35:0] acalCnt_q;
   assign acalFire = config1_q[`TCSR_CF1_AUTO_FSK_CAL_ENABLE] && (acalCnt_q == AUTO_FSK_CAL_ENABLE_CYCLES - 36'd1);
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         acalCnt_q <= 36'd0;
      end else if (clkEn) begin
         if (!config1_q[`TCSR_CF1_AUTO_FSK_CAL_ENABLE] || acalFire) begin
            acalCnt_q <= 36'd0;
         end else begin
            acalCnt_q <= acalCnt_q + 36'd1;
         end
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   tcsr_byte_t statusVal, rdByte;
   assign statusVal = {lockS, lnaS, xtalS, 3'b000, pollDoneSt_q, fskDoneSt_q};
   always_comb begin
      rdByte = 8'h00;
      if (hitIdx(paddr, `TCSR_IDX_CONTROL)) begin
         rdByte = control_q;
      end else if (hitIdx(paddr, `TCSR_IDX_CONFIG0)) begin
         rdByte = config0_q;
      end else if (hitIdx(paddr, `TCSR_IDX_CONFIG1)) begin
         rdByte = config1_q;
      end else if (hitIdx(paddr, `TCSR_IDX_STATUS)) begin
         rdByte = statusVal;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite) begin
            prdata <= {24'h00_0000, rdByte};
         end
      end
   end

   // ----------------------------------------
   // control outputs
   // ----------------------------------------
   logic txNext;
   assign txNext = config0_q[`TCSR_CF0_TX] || txRxS;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         agcLockEnable <= 1'b0;
         manualLevelMode <= 1'b0;
         lnaForceHigh <= 1'b0;
         peakTrackForce <= 1'b0;
         pollCalStart <= 1'b0;
         fskCalStart <= 1'b0;
         deepSleep <= 1'b0;
         fskMode <= 1'b0;
         txMode <= 1'b0;
         rxMode <= 1'b0;
         discontinuousRxEnable <= 1'b0;
         offPrescale <= 2'b00;
         onPrescale <= 2'b00;
         dataEnable <= 1'b0;
      end else if (clkEn) begin
         // gain and tracking
         agcLockEnable <= control_q[`TCSR_CTL_AGC_LOCK];
         manualLevelMode <= config0_q[`TCSR_CF0_MANUAL_LEVEL_MODE];
         lnaForceHigh <= config0_q[`TCSR_CF0_MANUAL_LEVEL_MODE] && control_q[`TCSR_CTL_GAIN];
         peakTrackForce <= control_q[`TCSR_CTL_TRACK];

         // calibration requests, high while running
         pollCalStart <= pollSt_q == TCSR_CAL_RUN;
         fskCalStart <= fskSt_q == TCSR_CAL_RUN;

         // sleep overrides txMode and rxMode; fskMode and discontinuousRxEnable are not gated
         deepSleep <= control_q[`TCSR_CTL_SLEEP];

         // modulation and direction
         fskMode <= config0_q[`TCSR_CF0_FSK];
         txMode <= txNext && !control_q[`TCSR_CTL_SLEEP];
         rxMode <= !txNext && !control_q[`TCSR_CTL_SLEEP];

         // discontinuous receive and its timer bases
         discontinuousRxEnable <= config0_q[`TCSR_CF0_DRX];
         offPrescale <= config0_q[`TCSR_CF0_OFF_HI:`TCSR_CF0_OFF_LO];
         onPrescale <= config0_q[`TCSR_CF0_ON_HI:`TCSR_CF0_ON_LO];

         // no data path while unlocked or asleep
         dataEnable <= lockS && !control_q[`TCSR_CTL_SLEEP];
      end
   end

   // dwell = 2^(9 + 2n) crystal periods
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         agcDwellCycles <= 24'h00_0200;
      end else if (clkEn) begin
         agcDwellCycles <= 24'h00_0001 << (`TCSR_DWELL_K_BASE
            + 2 * config1_q[`TCSR_CF1_DWELL_HI:`TCSR_CF1_DWELL_LO]);
      end
   end

   // ----------------------------------------
   // clock output divider
   // ----------------------------------------
   // crystal is the core clock, so every ratio is one step slower than nominal;
   // each code still gives its own rate, twice the period of the code below
   logic [3:0] divCnt_q;
   logic clkActive;

   assign clkActive = control_q[`TCSR_CTL_DIVIDED_CLOCK_PIN]
      && (config1_q[`TCSR_CF1_CONT]
          || (config0_q[`TCSR_CF0_DRX] ? onS : enS));
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         divCnt_q <= 4'd0;
         dividedClockPin <= 1'b0;
      end else if (clkEn) begin
         divCnt_q <= divCnt_q + 4'd1;
         if (!clkActive) begin
            dividedClockPin <= 1'b0;
         end else begin
            case (config1_q[`TCSR_CF1_DIV_HI:`TCSR_CF1_DIV_LO])
               2'b00: dividedClockPin <= ~dividedClockPin;
               2'b01: dividedClockPin <= divCnt_q[1];
               2'b10: dividedClockPin <= divCnt_q[2];
               default: dividedClockPin <= divCnt_q[3];
            endcase
         end
      end
   end
endmodule : tcsr_top

// *** logic/tcsr_regs.svh ***
`ifndef TCSR_REGS_SVH
`define TCSR_REGS_SVH
// register indices (byte address = 4 x index)
`define TCSR_IDX_CONTROL 8'h01
`define TCSR_IDX_CONFIG0 8'h02
`define TCSR_IDX_CONFIG1 8'h03
`define TCSR_IDX_STATUS 8'h1A
// control fields
`define TCSR_CTL_AGC_LOCK 7
`define TCSR_CTL_GAIN 6
`define TCSR_CTL_TRACK 5
`define TCSR_CTL_POLL_TIMER_CAL_START 3
`define TCSR_CTL_FSK_CAL_START 2
`define TCSR_CTL_DIVIDED_CLOCK_PIN 1
`define TCSR_CTL_SLEEP 0
`define TCSR_CTL_MASK 8'hEF
// config0 fields
`define TCSR_CF0_FSK 7
`define TCSR_CF0_TX 6
`define TCSR_CF0_MANUAL_LEVEL_MODE 5
`define TCSR_CF0_DRX 4
`define TCSR_CF0_OFF_HI 3
`define TCSR_CF0_OFF_LO 2
`define TCSR_CF0_ON_HI 1
`define TCSR_CF0_ON_LO 0
// config1 fields
`define TCSR_CF1_AUTO_FSK_CAL_ENABLE 6
`define TCSR_CF1_CONT 5
`define TCSR_CF1_DIV_HI 4
`define TCSR_CF1_DIV_LO 3
`define TCSR_CF1_DWELL_HI 2
`define TCSR_CF1_DWELL_LO 0
`define TCSR_CF1_MASK 8'h7F
// status fields
`define TCSR_ST_LOCK 7
`define TCSR_ST_GAIN 6
`define TCSR_ST_XTAL 5
`define TCSR_ST_POLL_CAL_DONE 1
`define TCSR_ST_FSK_CAL_DONE 0
// reset values
`define TCSR_RST_CONTROL 8'h00
`define TCSR_RST_CONFIG0 8'h00
`define TCSR_RST_CONFIG1 8'h00
// timing
`define TCSR_CLK_MHZ 125
`define TCSR_AUTO_FSK_CAL_ENABLE_PERIOD_S 60
`define TCSR_AUTO_FSK_CAL_ENABLE_CYCLES (`TCSR_AUTO_FSK_CAL_ENABLE_PERIOD_S * `TCSR_CLK_MHZ * 64'd1000000)
`define TCSR_DWELL_K_BASE 9
`endif

// *** logic/tcsr_pkg.sv ***
package tcsr_pkg;
   typedef logic [7:0] tcsr_byte_t;
   typedef logic [1:0] tcsr_sel_t;
   typedef enum logic [1:0] {
      TCSR_CAL_IDLE,
      TCSR_CAL_RUN
   } tcsr_cal_t;
endpackage : tcsr_pkg

// *** test/tcsr_top_properties.sv ***
module tcsr_top_properties #(
   parameter logic [35:0] AUTO_FSK_CAL_ENABLE_CYCLES = 36'd50
) (
   // observed ports
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pollCalBusy,
   input wire logic pollCalStart,
   input wire logic deepSleep,
   input wire logic txMode,
   input wire logic rxMode,
   input wire logic dataEnable,
   input wire logic manualLevelMode,
   input wire logic lnaForceHigh,
   input wire logic [23:0] agcDwellCycles
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic mapped = paddr inside {12'h004, 12'h008, 12'h00C, 12'h068};
   logic taken;
   assign taken = psel && penable && !pready;
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
   access_answer_a: assert property (taken |=> pready && (pslverr == !$past(mapped)))
      else $error("bad apb answer");
   sleep_quiet_a: assert property (deepSleep |-> !txMode && !rxMode)
      else $error("radio active in sleep");
   mode_excl_a: assert property (!(txMode && rxMode)) else $error("tx and rx together");
   data_gate_a: assert property (dataEnable |-> !deepSleep) else $error("data while asleep");
   gain_force_a: assert property (lnaForceHigh |-> manualLevelMode)
      else $error("gain forced without manual mode");
   dwell_pow_a: assert property ($onehot(agcDwellCycles) && |(agcDwellCycles & 24'hAAAA00))
      else $error("dwell not odd power");
   poll_clear_a: assert property ($fell(pollCalBusy) |-> ##8 !pollCalStart)
      else $error("poll cal never ends");
   cover property (taken ##1 pslverr);
   cover property ($fell(pollCalStart));
   cover property (txMode ##[1:200] rxMode);
endmodule : tcsr_top_properties

bind tcsr_top tcsr_top_properties #(.AUTO_FSK_CAL_ENABLE_CYCLES(AUTO_FSK_CAL_ENABLE_CYCLES)) u_props (
   .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .pollCalBusy(pollCalBusy), .pollCalStart(pollCalStart),
   .deepSleep(deepSleep), .txMode(txMode), .rxMode(rxMode), .dataEnable(dataEnable),
   .manualLevelMode(manualLevelMode), .lnaForceHigh(lnaForceHigh),
   .agcDwellCycles(agcDwellCycles));

// *** test/tcsr_apb_host.sv ***
module tcsr_apb_host (
   // apb master
   input wire logic core_clk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hF;
   end
   // one transfer, entered right after a rising edge
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      @(posedge core_clk);
   endtask : xfer
endmodule : tcsr_apb_host

// *** test/transceiver_control_status_regs_tb.sv ***
module transceiver_control_status_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, enablePin, txRxPin;
   logic pllLockRaw, lnaHighRaw, xtalAliveRaw, pollCalBusy, fskCalBusy, drxOnPeriod;
   logic agcLock, manMode, lnaHigh, trkForce, pollStart, fskStart, deepSleep, fskMode;
   logic txMode, rxMode, drxEn, dataEnable, clkPin, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   tcsr_pkg::tcsr_sel_t offPre, onPre;
   logic [23:0] dwell;
   logic [15:0] rs = 16'h9A6B;
   logic [7:0] c, f0, f1, p, q;
   int errTotal = 0;
   int checked = 0;
   int n, k;
   tcsr_top #(.AUTO_FSK_CAL_ENABLE_CYCLES(36'd50)) u_dut (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .enablePin(enablePin), .txRxPin(txRxPin), .pllLockRaw(pllLockRaw),
      .lnaHighRaw(lnaHighRaw), .xtalAliveRaw(xtalAliveRaw), .pollCalBusy(pollCalBusy),
      .fskCalBusy(fskCalBusy), .drxOnPeriod(drxOnPeriod), .agcLockEnable(agcLock),
      .manualLevelMode(manMode), .lnaForceHigh(lnaHigh), .peakTrackForce(trkForce),
      .pollCalStart(pollStart), .fskCalStart(fskStart), .deepSleep(deepSleep),
      .fskMode(fskMode), .txMode(txMode), .rxMode(rxMode), .discontinuousRxEnable(drxEn),
      .offPrescale(offPre), .onPrescale(onPre), .agcDwellCycles(dwell),
      .dataEnable(dataEnable), .dividedClockPin(clkPin));
   tcsr_apb_host u_host (.core_clk(core_clk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb));
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic [9:0] expOut(input logic [7:0] cc, input logic [7:0] ff,
                                         input logic tr, input logic lk);
      logic tx;
      tx = ff[6] | tr;
      return {cc[7], cc[5], cc[0], ff[7], ff[4], ff[5], ff[5] & cc[6], tx & !cc[0],
              !tx & !cc[0], lk & !cc[0]};
   endfunction : expOut
   task automatic chkReg(input logic [7:0] g, input logic [7:0] x);
      checked++;
      if (g !== x) begin
         errTotal++;
         $display("unexpected at %0t: register got %h want %h", $time, g, x);
      end
   endtask : chkReg
   task automatic chkOut(input logic [23:0] g, input logic [23:0] x);
      checked++;
      if (g !== x) begin
         errTotal++;
         $display("unexpected at %0t: output got %h want %h", $time, g, x);
      end
   endtask : chkOut
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      u_host.xfer(1'b1, idx, d, q, e);
   endtask : wr
   task automatic rdChk(input logic [7:0] idx, input logic [7:0] x);
      u_host.xfer(1'b0, idx, 8'h00, q, e);
      chkReg(q, x);
   endtask : rdChk
   task automatic toggles();
      logic last;
      n = 0;
      last = clkPin;
      repeat (64) begin
         @(posedge core_clk);
         if (clkPin !== last) n++;
         last = clkPin;
      end
   endtask : toggles
   task automatic calDone(input logic b);
      if (b) fskCalBusy <= 1'b1;
      else pollCalBusy <= 1'b1;
      repeat (5) @(posedge core_clk);
      fskCalBusy <= 1'b0;
      pollCalBusy <= 1'b0;
      repeat (8) @(posedge core_clk);
   endtask : calDone
   task automatic results();
      if (errTotal == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   // ------------------------------
   // stimulus
   // ------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      errTotal++;
      results();
   end
   initial begin
      {resetn, enablePin, txRxPin, pllLockRaw, lnaHighRaw} = 5'b0;
      {xtalAliveRaw, pollCalBusy, fskCalBusy, drxOnPeriod} = 4'b0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         c = rs[7:0];
         p = rs[15:8];
         rs = lfsr(rs);
         f0 = rs[7:0];
         f1 = {rs[15], 1'b0, rs[13:11], i[2:0]};
         {enablePin, drxOnPeriod, xtalAliveRaw, lnaHighRaw, pllLockRaw, txRxPin} <= p[5:0];
         wr(8'h01, c & 8'hF3);
         wr(8'h02, f0);
         wr(8'h03, f1);
         rdChk(8'h01, c & 8'hE3);
         rdChk(8'h02, f0);
         rdChk(8'h03, f1 & 8'h7F);
         wr(8'h1A, 8'hFF);
         rdChk(8'h1A, {p[1], p[2], p[3], 5'h00});
         chkOut({14'h0, agcLock, trkForce, deepSleep, fskMode, drxEn, manMode, lnaHigh,
                 txMode, rxMode, dataEnable}, {14'h0, expOut(c, f0, p[0], p[1])});
         chkOut({20'h0, offPre, onPre}, {20'h0, f0[3:0]});
         chkOut(dwell, 24'h1 << (9 + 2 * i));
      end
      u_host.xfer(1'b0, 8'h04, 8'h00, q, e);
      chkReg({q[6:0], e}, 8'h01);
      for (int b = 0; b < 2; b++) begin
         wr(8'h01, 8'h08 >> b);
         repeat (4) @(posedge core_clk);
         rdChk(8'h01, 8'h08 >> b);
         chkOut({23'h0, b ? fskStart : pollStart}, 24'h1);
         u_host.xfer(1'b0, 8'h1A, 8'h00, q, e);
         chkReg(q & 8'h03, {6'h0, b[0], 1'b0});
         calDone(b[0]);
         rdChk(8'h01, 8'h00);
         u_host.xfer(1'b0, 8'h1A, 8'h00, q, e);
         chkReg(q & 8'h03, {7'h1, b[0]});
      end
      wr(8'h03, 8'h40);
      for (k = 0; k < 200 && fskStart !== 1'b1; k++) @(posedge core_clk);
      chkOut({23'h0, fskStart}, 24'h1);
      wr(8'h03, 8'h00);
      calDone(1'b1);
      rdChk(8'h01, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h01, 8'h02);
      for (int d = 0; d < 4; d++) begin
         wr(8'h03, {3'b001, d[1:0], 3'b000});
         toggles();
         chkOut(24'(n > (64 >> d) - 2 && n < (64 >> d) + 2), 24'h1);
      end
      enablePin <= 1'b0;
      wr(8'h03, 8'h00);
      repeat (8) @(posedge core_clk);
      toggles();
      chkOut({n[22:0], clkPin}, 24'h0);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h20);
      toggles();
      chkOut({n[22:0], clkPin}, 24'h0);
      results();
   end
endmodule : transceiver_control_status_regs_tb
